// ### hdl/cbs_pkg.sv
// constants and types for the coefficient bank-swap and sample-start control
// Operation
// - host writes swap bit, swap becomes pending
// - pending swap commits at next sample-start sampling
// - system control swap bit also requests swap
// - early request may commit at once
// - late request may slip one sampling
// - busy high from request until commit
// - other registers stay accessible meanwhile
// - master mode: data write drives start high
// - master mode: all but data input accessible
// - minimum ignore period by width, then poll
package cbs_pkg;
    // clock and master start timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int GO_EXTRA_NS = 50;
    localparam int GO_CLK_PERIODS = 2;
    localparam int GO_MAX_CYCLES = GO_CLK_PERIODS + GO_EXTRA_NS / CLK_PERIOD_NS;
    // field positions in the two control registers
    localparam int ACCESS_SWAP_BIT = 0;
    localparam int SYSTEM_SWAP_BIT = 2;
    // coefficient width codes
    localparam logic [1:0] CW_4 = 2'h0;
    localparam logic [1:0] CW_8 = 2'h1;
    localparam logic [1:0] CW_12 = 2'h2;
    localparam logic [1:0] CW_16 = 2'h3;
    localparam logic [3:0] HOLD_4 = 4'h2;
    localparam logic [3:0] HOLD_8 = 4'h4;
    localparam logic [3:0] HOLD_12 = 4'h6;
    localparam logic [3:0] HOLD_16 = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    // sampling state, one-hot
    typedef enum logic [1:0] {
        SMP_POLL = 2'b01,
        SMP_HOLD = 2'b10
    } cbs_smp_t;
    // minimum ignore period for a width code
    function automatic logic [3:0] cbs_hold(input logic [1:0] cw);
        case (cw)
            CW_4: cbs_hold = HOLD_4;
            CW_8: cbs_hold = HOLD_8;
            CW_12: cbs_hold = HOLD_12;
            default: cbs_hold = HOLD_16;
        endcase
    endfunction
endpackage

// ### hdl/cbs_sync.sv
// two-flop synchroniser for the sample-start pin
`timescale 1ns/1ps
`default_nettype none
module cbs_sync (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic din,
    output logic dout
);
    // first stage feeds only the second
    typedef struct packed {
        logic meta;
        logic stable;
    } cbs_sync_t;
    cbs_sync_t st;
    cbs_sync_t next_st;
    // shift the pin in
    always_comb
    begin
        next_st.meta = din;
        next_st.stable = st.meta;
    end
    // register stages
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            st <= '0;
        else
            st <= next_st;
    end
    assign dout = st.stable;
endmodule
`default_nettype wire

// ### hdl/cbs_go_control.sv
// bank-swap request, commit and sample-start sequencing
`timescale 1ns/1ps
`default_nettype none
module cbs_go_control (
    input wire logic clk,
    input wire logic arst_n,
    // host write strobe for the access control register
    input wire logic accessCtrlWrite,
    input wire logic [7:0] accessCtrlData,
    // system control register image, level
    input wire logic [7:0] systemCtrl,
    // host write to the data input register
    input wire logic dataInWrite,
    // master mode select and coefficient width code
    input wire logic masterMode,
    input wire logic [1:0] coefWidth,
    // sample-start pin as seen from outside
    input wire logic goIn,
    // sample-start drive, output enable low while driving
    output logic goOut,
    output logic goOe_n,
    // status
    output logic busy,
    output logic swapPending,
    output logic activeBank,
    output logic hostBank,
    output logic sampleStart,
    output logic sampleWindow,
    output logic coefAccessOk,
    output logic dataInAccessOk
);
    import cbs_pkg::*;

    // whole module state
    typedef struct packed {
        cbs_smp_t smp;
        logic [3:0] cnt;
        logic pending;
        logic bank;
        logic sysSeen;
        logic goDrive;
        logic startPulse;
    } cbs_state_t;

    cbs_state_t st;
    cbs_state_t next_st;
    logic goSync;
    logic sampling;
    logic goHigh;
    logic reqAccess;
    logic reqSystem;

    // pin passes two flops before use
    cbs_sync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .din(goIn),
        .dout(goSync)
    );

    // master sees its own drive directly, no pin round trip; the synced
    // echo of its own pulse lags two clocks and would start a second sample
    assign goHigh = masterMode ? st.goDrive : goSync;
    // an edge on which sample-start is sampled at all
    assign sampling = (st.smp == SMP_POLL);
    assign reqAccess = accessCtrlWrite & accessCtrlData[ACCESS_SWAP_BIT];
    assign reqSystem = systemCtrl[SYSTEM_SWAP_BIT] & ~st.sysSeen;

    // next-state logic
    always_comb
    begin
        next_st = st;
        next_st.startPulse = 1'b0;
        next_st.sysSeen = systemCtrl[SYSTEM_SWAP_BIT];
        if (sampling && st.pending)
        begin
            next_st.bank = ~st.bank;
            next_st.pending = 1'b0;
        end
        // request arriving on a sampling edge waits one more
        // sampling; set beats clear so it is never lost
        if (reqAccess || reqSystem)
            next_st.pending = 1'b1;
        case (st.smp)
            SMP_POLL:
            begin
                if (goHigh)
                begin
                    next_st.smp = SMP_HOLD;
                    next_st.cnt = cbs_hold(coefWidth) - CNT_ONE;
                    next_st.startPulse = 1'b1;
                    next_st.goDrive = 1'b0;
                end
            end
            SMP_HOLD:
            begin
                // ignore the pin until the minimum period has passed
                if (st.cnt <= CNT_ONE)
                    next_st.smp = SMP_POLL;
                next_st.cnt = (st.cnt == CNT_ZERO) ? CNT_ZERO : st.cnt - CNT_ONE;
            end
            default:
            begin
                next_st.smp = SMP_POLL;
                next_st.cnt = CNT_ZERO;
            end
        endcase
        // master drives start after data write, within one cycle
        if (masterMode && dataInWrite)
            next_st.goDrive = 1'b1;
        if (!masterMode)
            next_st.goDrive = 1'b0;
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st.smp <= SMP_POLL;
            st.cnt <= CNT_ZERO;
            st.pending <= 1'b0;
            st.bank <= 1'b0;
            st.sysSeen <= 1'b0;
            st.goDrive <= 1'b0;
            st.startPulse <= 1'b0;
        end
        else
            st <= next_st;
    end

    assign busy = st.pending;
    assign swapPending = st.pending;
    assign activeBank = st.bank;
    assign hostBank = ~st.bank;
    assign goOut = st.goDrive;
    // active-low enable; drives only in master mode
    assign goOe_n = ~masterMode;
    assign sampleStart = st.startPulse;
    assign sampleWindow = (st.smp == SMP_HOLD);
    // advise host: no coefficient access while swap pending
    assign coefAccessOk = ~st.pending;
    // other registers always open; data input closed while driving
    assign dataInAccessOk = ~(masterMode & st.goDrive);
    // the host waits for busy low before requesting again
endmodule
`default_nettype wire

// ### tb/cbs_chk_assertions.sv
// concurrent checks on the bank-swap and start control ports
`timescale 1ns/1ps
`default_nettype none
module cbs_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic accessCtrlWrite,
    input wire logic [7:0] accessCtrlData,
    input wire logic dataInWrite,
    input wire logic masterMode,
    input wire logic goOut,
    input wire logic goOe_n,
    input wire logic busy,
    input wire logic swapPending,
    input wire logic activeBank,
    input wire logic hostBank,
    input wire logic coefAccessOk
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_req; accessCtrlWrite && accessCtrlData[0] |=> swapPending; endproperty
    a_req: assert property (p_req) else $error("swap lost");
    property p_idle; !swapPending |-> !busy; endproperty
    a_idle: assert property (p_idle) else $error("busy idle");
    property p_bank; activeBank != hostBank; endproperty
    a_bank: assert property (p_bank) else $error("banks");
    property p_flip; $changed(activeBank) |-> $past(busy); endproperty
    a_flip: assert property (p_flip) else $error("stray swap");
    property p_clr; $fell(swapPending) |-> $changed(activeBank); endproperty
    a_clr: assert property (p_clr) else $error("no flip");
    property p_go; masterMode && dataInWrite |-> ##[1:12] goOut; endproperty
    a_go: assert property (p_go) else $error("no start");
    property p_oe; goOe_n == !masterMode; endproperty
    a_oe: assert property (p_oe) else $error("drive");
    property p_coef; coefAccessOk == !swapPending; endproperty
    a_coef: assert property (p_coef) else $error("coef");
endmodule
bind cbs_go_control cbs_chk u_cbs_chk (.*);
`default_nettype wire

// ### tb/cbs_far.sv
// far-side master that drives the shared start line
`timescale 1ns/1ps
`default_nettype none
module cbs_far (
    input wire logic clk,
    input wire logic fire,
    output logic go
);
    // one-clock start pulse, low between starts
    initial go = 1'b0;
    always @(posedge clk)
    begin
        go <= fire;
    end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// bench for the bank-swap and start control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cbs_pkg::*;
    typedef struct packed {logic viaSys; logic [1:0] cw; logic bank;} cbs_row_t;
    cbs_row_t rows [4] = '{'{1'b0, CW_4, 1'b1}, '{1'b1, CW_8, 1'b0},
        '{1'b0, CW_12, 1'b1}, '{1'b1, CW_16, 1'b0}};
    logic clk = 1'b0, arst_n = 1'b0, accessCtrlWrite = 1'b0, dataInWrite = 1'b0;
    logic masterMode = 1'b1, fire = 1'b0, farGo, goOut, goOe_n, busy, swapPending;
    logic activeBank, hostBank, sampleStart, sampleWindow, coefAccessOk, dataInAccessOk;
    logic [7:0] accessCtrlData = 8'h01, systemCtrl = 8'h00;
    logic [1:0] coefWidth = CW_4;
    // released pin follows whoever drives it
    wire goIn = goOe_n ? farGo : goOut;
    int error_cnt = 0, check_count = 0, k;
    always #2.5 clk = ~clk;
    cbs_far u_cbs_far (.clk, .fire, .go(farGo));
    cbs_go_control u_cbs_go_control (.*);
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic seen, input logic exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: saw %b", $time, seen);
        end
    endtask
    // one swap request through either register
    task automatic req(input logic viaSys);
        accessCtrlWrite = !viaSys;
        systemCtrl[2] = viaSys;
        tick(1);
        accessCtrlWrite = 1'b0;
        systemCtrl[2] = 1'b0;
    endtask
    task automatic wait_idle();
        for (k = 0; k < 40 && busy !== 1'b0; k++) tick(1);
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        tick(3);
        arst_n = 1'b1;
        check(hostBank, 1'b1);
        foreach (rows[i])
        begin
            coefWidth = rows[i].cw;
            req(rows[i].viaSys);
            check(busy, 1'b1);
            dataInWrite = 1'b1;
            tick(1);
            dataInWrite = 1'b0;
            check(goOut, 1'b1);
            check(dataInAccessOk, 1'b0);
            wait_idle();
            check(activeBank, rows[i].bank);
        end
        // request inside the ignore period must wait
        dataInWrite = 1'b1;
        tick(1);
        dataInWrite = 1'b0;
        for (k = 0; k < 20 && sampleStart !== 1'b1; k++) tick(1);
        check(sampleWindow, 1'b1);
        check(dataInAccessOk, 1'b1);
        req(1'b0);
        tick(1);
        check(busy, 1'b1);
        wait_idle();
        check(activeBank, 1'b1);
        masterMode = 1'b0;
        #0.1;
        check(goOe_n, 1'b1);
        req(1'b1);
        fire = 1'b1;
        tick(1);
        fire = 1'b0;
        wait_idle();
        check(swapPending, 1'b0);
        give_verdict();
    end
    // far beyond the few dozen cycles the run needs
    initial
    begin
        #20000;
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
